// [hw/slcc_regs.vh]
// Constants for the serial latch clear control block
// Assumes inclusion by hw/slcc_top.v and hw/slcc_decode.v
`ifndef SLCC_REGS_VH
`define SLCC_REGS_VH
`define SLCC_ADDR_AB 4'h0
`define SLCC_ADDR_C 4'h4
`define SLCC_ADDR_STATUS 4'h8
`define SLCC_RSVD_HI_LSB 5
`define SLCC_RSVD_HI_RESET 3'h0
`define SLCC_CODE_MSB 3
`define SLCC_CODE_RESET 4'hF
`define SLCC_CODE_FIRST 4'h5
`define SLCC_CODE_SECOND 4'h6
`define SLCC_CODE_BOTH 4'h7
`define SLCC_RESP_OKAY 2'h0
`define SLCC_RESP_SLVERR 2'h2
`endif

// [hw/slcc_decode.v]
// Clear code decoder for one register copy
// Assumes a registered write strobe and code from the top level
`timescale 1ns/10ps
`default_nettype none
`include "slcc_regs.vh"
module slcc_decode #(
  parameter UNIT_C = 0
) (
  // Write event
  input wire wr_stb,
  input wire [3:0] code,
  // Clear requests
  output wire clr_first,
  output wire clr_second
);
  wire hit_first;
  wire hit_second;
  wire hit_both;
  assign hit_first = (code == `SLCC_CODE_FIRST);
  assign hit_second = (code == `SLCC_CODE_SECOND);
  assign hit_both = (code == `SLCC_CODE_BOTH);
  generate
    if (UNIT_C != 0) begin : g_c
      // 0110 prohibited here
      assign clr_first = wr_stb & (hit_first | hit_both);
      assign clr_second = 1'b0;
    end else begin : g_ab
      assign clr_first = wr_stb & (hit_first | hit_both);
      assign clr_second = wr_stb & (hit_second | hit_both);
    end
  endgenerate
endmodule
`default_nettype wire

// [hw/slcc_top.v]
// Serial latch clear control register bank with AXI4-Lite slave
// Assumes clk at 25 MHz, rst asynchronous active high, ce freezes all state
`timescale 1ns/10ps
`default_nettype none
`include "slcc_regs.vh"
module slcc_top (
  // Clock, reset, enable
  input wire clk,
  input wire rst,
  input wire ce,
  // AXI4-Lite write address
  input wire [3:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [3:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Ready flag set events from the serial units
  input wire [2:0] rx_ready_set,
  // Clear strobes to serial units a, b, c
  output wire [2:0] unit_clear,
  // Receive data ready flags
  output wire [2:0] receive_data_ready_flag
);
  reg aw_held_ff;
  reg [3:0] aw_addr_ff;
  reg w_held_ff;
  reg [31:0] w_data_ff;
  reg [3:0] w_strb_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;
  reg [2:0] rsvd_ab_ff;
  reg [2:0] rsvd_c_ff;
  reg wr_ab_ff;
  reg wr_c_ff;
  reg [3:0] code_ff;
  reg [2:0] clear_ff;
  reg [2:0] ready_ff;
  reg [31:0] nxt_rdata;
  reg [1:0] nxt_rresp;
  wire do_write;
  wire map_ab;
  wire map_c;
  wire map_st;
  wire [2:0] clr_req;
  wire unused_ok;

  assign unused_ok = ^{s_axi_awprot, s_axi_arprot, w_data_ff[31:8], w_data_ff[4]};
  assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_held_ff & ~bvalid_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign unit_clear = clear_ff;
  assign receive_data_ready_flag = ready_ff;

  assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign map_ab = (aw_addr_ff == `SLCC_ADDR_AB);
  assign map_c = (aw_addr_ff == `SLCC_ADDR_C);
  assign map_st = (aw_addr_ff == `SLCC_ADDR_STATUS);

  // Write channel capture and response
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 4'h0;
      w_held_ff <= 1'b0;
      w_data_ff <= 32'h0;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `SLCC_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= (map_ab | map_c | map_st) ? `SLCC_RESP_OKAY : `SLCC_RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Register copies: only a full low-byte write triggers a clear
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rsvd_ab_ff <= `SLCC_RSVD_HI_RESET;
      rsvd_c_ff <= `SLCC_RSVD_HI_RESET;
      wr_ab_ff <= 1'b0;
      wr_c_ff <= 1'b0;
      code_ff <= `SLCC_CODE_RESET;
    end else if (ce) begin
      wr_ab_ff <= do_write & map_ab & w_strb_ff[0];
      wr_c_ff <= do_write & map_c & w_strb_ff[0];
      if (do_write && w_strb_ff[0] && map_ab) begin
        rsvd_ab_ff <= w_data_ff[7:`SLCC_RSVD_HI_LSB];
      end
      if (do_write && w_strb_ff[0] && map_c) begin
        rsvd_c_ff <= w_data_ff[7:`SLCC_RSVD_HI_LSB];
      end
      // Code held only for the decode cycle, then back to ones
      if (do_write && w_strb_ff[0] && (map_ab || map_c)) begin
        code_ff <= w_data_ff[`SLCC_CODE_MSB:0];
      end else begin
        code_ff <= `SLCC_CODE_RESET;
      end
    end
  end

  slcc_decode #(
    .UNIT_C(0)
  ) u_dec_ab (
    .wr_stb(wr_ab_ff),
    .code(code_ff),
    .clr_first(clr_req[0]),
    .clr_second(clr_req[1])
  );

  slcc_decode #(
    .UNIT_C(1)
  ) u_dec_c (
    .wr_stb(wr_c_ff),
    .code(code_ff),
    .clr_first(clr_req[2]),
    .clr_second()
  );

  // Clear strobes and ready flags
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      clear_ff <= 3'h0;
      ready_ff <= 3'h0;
    end else if (ce) begin
      clear_ff <= clr_req;
      // Clear wins: the latch is being reinitialised
      ready_ff <= (ready_ff | rx_ready_set) & ~clr_req;
    end
  end

  // Read mux
  always @* begin
    nxt_rdata = 32'h0;
    nxt_rresp = `SLCC_RESP_OKAY;
    case (s_axi_araddr)
      `SLCC_ADDR_AB: nxt_rdata = {24'h0, rsvd_ab_ff, 1'b0, 4'hF};
      `SLCC_ADDR_C: nxt_rdata = {24'h0, rsvd_c_ff, 1'b0, 4'hF};
      `SLCC_ADDR_STATUS: nxt_rdata = {29'h0, ready_ff};
      default: nxt_rresp = `SLCC_RESP_SLVERR;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= `SLCC_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= nxt_rdata;
        rresp_ff <= nxt_rresp;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/slcc_assertions.sv]
// Checker for slcc_top: clear strobes and copy readback
// Assumes binding into slcc_top, one clock domain
`timescale 1ns/10ps
`default_nettype none
module slcc_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus requests and answers
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // Unit side
  input wire logic [2:0] unit_clear,
  input wire logic [2:0] receive_data_ready_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [3:0] wa_ff, wc_ff, ra_ff;
  // Master holds payload while valid, so capture on valid
  always_ff @(posedge clk) begin
    if (s_axi_awvalid) wa_ff <= s_axi_awaddr;
    if (s_axi_wvalid) wc_ff <= s_axi_wdata[3:0];
    if (s_axi_arvalid) ra_ff <= s_axi_araddr;
  end
  chk_ab_single:
    assert property ($rose(s_axi_bvalid) && wa_ff == 4'h0 && wc_ff inside {4'h5, 4'h6}
      |=> unit_clear == {1'h0, wc_ff == 4'h6, wc_ff == 4'h5}) else $error("single clear wrong");
  chk_ab_both:
    assert property ($rose(s_axi_bvalid) && wa_ff == 4'h0 && wc_ff == 4'h7
      |=> unit_clear == 3'h3) else $error("dual clear wrong");
  chk_c_unit:
    assert property ($rose(s_axi_bvalid) && wa_ff == 4'h4 && wc_ff inside {4'h5, 4'h7}
      |=> unit_clear == 3'h4) else $error("unit c clear wrong");
  chk_strobe_cause:
    assert property (|unit_clear |-> $past(s_axi_bvalid)) else $error("strobe without write");
  chk_read_ones:
    assert property (s_axi_rvalid && !ra_ff[3] |-> s_axi_rdata[3:0] == 4'hF)
      else $error("code bits not ones");
  chk_bit4_zero:
    assert property (s_axi_rvalid && !ra_ff[3] |-> !s_axi_rdata[4]) else $error("bit4 not zero");
  chk_flag_drop:
    assert property (|unit_clear |-> (receive_data_ready_flag & unit_clear) == 3'h0)
      else $error("flag kept");
  chk_pulse_once:
    assert property (|unit_clear |=> unit_clear == 3'h0) else $error("strobe too long");
endmodule
bind slcc_top slcc_assertions chk_i (.*);
`default_nettype wire

// [tb/tb_slcc_top.sv]
// Bench for slcc_top: clear codes written over AXI4-Lite
// Assumes slcc_top and its checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_slcc_top;
  logic clk = 0, rst = 1, ce = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hF;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0, rx_ready_set = '0;
  logic [2:0] unit_clear, receive_data_ready_flag;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_fail = 0, checks_done = 0, k;
  slcc_top uut (.*);
  initial forever #20 clk = ~clk;
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  function logic [2:0] exp_clr(input logic [3:0] a, c);
    if (a == 4'h0 && c inside {4'h5, 4'h6, 4'h7}) return c[1:0];
    if (a == 4'h4 && c inside {4'h5, 4'h7}) return 3'h4;
    return 3'h0;
  endfunction
  // Handshakes sampled mid-cycle, acted on at the following rising edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_go, w_go, b_go;
    b_go = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (int i = 0; i < 50 && !b_go; i++) begin
      @(negedge clk);
      aw_go = s_axi_awvalid && s_axi_awready;
      w_go = s_axi_wvalid && s_axi_wready;
      b_go = s_axi_bvalid;
      if (b_go) chk("bresp", {a == 4'hC, 1'h0}, s_axi_bresp);
      @(posedge clk);
      if (aw_go) s_axi_awvalid <= 0;
      if (w_go) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 0;
    if (!b_go) begin
      n_fail++;
      end_sim;
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
    logic a_go, r_go;
    r_go = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (int i = 0; i < 50 && !r_go; i++) begin
      @(negedge clk);
      a_go = s_axi_arvalid && s_axi_arready;
      r_go = s_axi_rvalid;
      if (r_go) begin
        chk("rdata", e, s_axi_rdata);
        chk("rresp", r, s_axi_rresp);
      end
      @(posedge clk);
      if (a_go) s_axi_arvalid <= 0;
    end
    s_axi_rready <= 0;
    if (!r_go) begin
      n_fail++;
      end_sim;
    end
  endtask
  // Set all flags, write code with bit 4 high, collect strobes
  task automatic shot(input logic [3:0] a, c);
    logic [2:0] e, got;
    e = exp_clr(a, c);
    got = 0;
    rx_ready_set <= 3'h7;
    @(posedge clk);
    rx_ready_set <= 0;
    wr(a, {27'h0, 1'h1, c});
    repeat (3) begin
      @(negedge clk);
      got |= unit_clear;
    end
    @(posedge clk);
    chk("unit_clear", e, got);
    rd(4'h8, {29'h0, ~e}, 2'h0);
    if (!a[3]) rd(a, 32'hF, 2'h0);
  endtask
  initial begin
    k = $urandom(6158);
    repeat (2) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rd(4'h0, 32'hF, 2'h0);
    for (k = 0; k < 32; k++) shot({1'h0, k[4], 2'h0}, k[3:0]);
    repeat (40) shot(4'($urandom) & 4'hC, 4'($urandom));
    rd(4'hC, 32'h0, 2'h2);
    end_sim;
  end
endmodule
`default_nettype wire
